// >>> rtl/psic_defines.svh
// offsets, field positions and reset values for the phy status/irq block
`ifndef PSIC_DEFINES_SVH
`define PSIC_DEFINES_SVH
// register indices; byte address is four times the index
`define PSIC_IDX_STATUS 8'h10
`define PSIC_IDX_ICTRL 8'h11
`define PSIC_IDX_EVENT 8'h12
// status summary fields
`define PSIC_STS_LINK 0
`define PSIC_STS_SPEED10 1
`define PSIC_STS_DUPLEX 2
`define PSIC_STS_LOOPBACK 3
`define PSIC_STS_ANEG_DONE 4
`define PSIC_STS_JABBER 5
// interrupt control fields
`define PSIC_IC_PIN_OE 0
`define PSIC_IC_EV_EN 1
`define PSIC_IC_TEST 2
`define PSIC_IC_MASK 16'h0007
// event register: status at 14:8, enables at 6:0
`define PSIC_EV_STAT_LSB 8
`define PSIC_EV_NUM 7
`define PSIC_RST_ICTRL 3'h0
`define PSIC_RST_EV_EN 7'h00
`endif

// >>> rtl/psic_pkg.sv
// types for the phy status/irq block
package psic_pkg;
    // event source order, lsb first, matches the event register layout
    typedef enum logic [2:0] {
        PSIC_EV_RXERR_HALF = 3'h0,
        PSIC_EV_FCS_HALF = 3'h1,
        PSIC_EV_ANEG_DONE = 3'h2,
        PSIC_EV_DUPLEX = 3'h3,
        PSIC_EV_SPEED = 3'h4,
        PSIC_EV_LINK = 3'h5,
        PSIC_EV_ENERGY = 3'h6
    } psic_event_t;
    typedef enum logic [1:0] {
        PSIC_APB_IDLE = 2'b01,
        PSIC_APB_DONE = 2'b10
    } psic_apb_state_t;
endpackage

// >>> rtl/psic_sync.sv
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ns
module psic_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // psic_sync

// >>> rtl/psic_top.sv
// phy status summary, event latching and interrupt control with apb slave
`timescale 1ns/1ns
`include "psic_defines.svh"
// Function
// - duplex bit 2: 1 full, 0 half
// - duplex/speed meaningful only with valid link
// - speed bit 1: 1 is 10, 0 is 100
// - link bit mirrors basic status, read-stable
// - control bits 15:3 ignore writes, read 0
// - test bit forces interrupt while set
// - global enable gates all event interrupts
// - pin enable bit selects irq output or powerdown
// - seven event sources supported
// - event bit set if occurred since last read
// - irq needs event enable and global enable
// - events latch even when not enabled
// - jabber mirrors basic status, read-stable
// - loopback bit 1 enabled, 0 normal
// - autoneg complete reads 0 until done
// - pending event cleared by the returning read
module psic_top
    import psic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_up,
    input wire logic speed_10,
    input wire logic full_duplex,
    input wire logic loopback_on,
    input wire logic aneg_enabled,
    input wire logic aneg_complete,
    input wire logic jabber_seen,
    input wire logic energy_detect,
    input wire logic fcs_cnt_half,
    input wire logic rxerr_cnt_half,
    input wire logic powerdown_or_irq_pin_i,
    output logic powerdown_or_irq_pin_o,
    output logic powerdown_or_irq_pin_oe,
    output logic powerdown_req,
    output logic irq_pending
);
    localparam int NEV = `PSIC_EV_NUM;

    // pin-side status levels, all from the phy core or a pin
    logic [9:0] raw_in;
    logic [9:0] sync_in;
    logic s_link, s_spd10, s_dup, s_loop, s_anen, s_andone, s_jab;
    logic s_energy, s_fhalf, s_rhalf, s_pd_pin;
    logic s_pd_pin_q;
    logic [NEV-1:0] lvl_q;
    logic [NEV-1:0] lvl_now;
    logic [NEV-1:0] ev_hit;
    logic [NEV-1:0] ev_stat_q;
    logic [NEV-1:0] ev_en_q;
    logic [2:0] ictrl_q;
    logic status_valid;
    logic irq_d;
    logic rd_event;
    logic acc_fire;
    logic addr_ok;
    logic [7:0] idx;
    logic [15:0] rdata_d;
    logic [2:0] lvl_init_q;
    logic [3:0] oe_hist_q;
    logic sel_status;
    logic sel_ictrl;
    logic sel_event;
    psic_apb_state_t apb_q;

    assign raw_in = {rxerr_cnt_half, fcs_cnt_half, energy_detect,
                     jabber_seen, aneg_complete, aneg_enabled,
                     loopback_on, full_duplex, speed_10, link_up};

    psic_sync #(.WIDTH(10)) u_sync_status
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    psic_sync #(.WIDTH(1)) u_sync_pin
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(powerdown_or_irq_pin_i),
        .sync_out(s_pd_pin)
    );

    assign {s_rhalf, s_fhalf, s_energy, s_jab, s_andone, s_anen,
            s_loop, s_dup, s_spd10, s_link} = sync_in;

    // duplex and speed only guaranteed with link and settled autoneg
    assign status_valid = s_link & (~s_anen | s_andone);

    // levels whose edges are events, in event register order
    assign lvl_now = {s_energy, s_link, s_spd10, s_dup, s_andone,
                      s_fhalf, s_rhalf};

    // any change of a level between the previous and the live sample
    function automatic logic lvl_changed(input logic now_v,
                                         input logic was_v);
        return now_v ^ was_v;
    endfunction

    // low-to-high only; a counter leaving half-full is no news
    function automatic logic lvl_rose(input logic now_v,
                                      input logic was_v);
        return now_v & ~was_v;
    endfunction

    // energy and link flag any change; speed/duplex change counts only
    // while the status is meaningful; the rest flag a rising edge
    always_comb
    begin
        ev_hit = '0;
        if (lvl_init_q[2])
        begin
            ev_hit[PSIC_EV_ENERGY] = lvl_changed(
                lvl_now[PSIC_EV_ENERGY], lvl_q[PSIC_EV_ENERGY]);
            ev_hit[PSIC_EV_LINK] = lvl_changed(
                lvl_now[PSIC_EV_LINK], lvl_q[PSIC_EV_LINK]);
            ev_hit[PSIC_EV_SPEED] = status_valid & lvl_changed(
                lvl_now[PSIC_EV_SPEED], lvl_q[PSIC_EV_SPEED]);
            ev_hit[PSIC_EV_DUPLEX] = status_valid & lvl_changed(
                lvl_now[PSIC_EV_DUPLEX], lvl_q[PSIC_EV_DUPLEX]);
            ev_hit[PSIC_EV_ANEG_DONE] = lvl_rose(
                lvl_now[PSIC_EV_ANEG_DONE], lvl_q[PSIC_EV_ANEG_DONE]);
            ev_hit[PSIC_EV_FCS_HALF] = lvl_rose(
                lvl_now[PSIC_EV_FCS_HALF], lvl_q[PSIC_EV_FCS_HALF]);
            ev_hit[PSIC_EV_RXERR_HALF] = lvl_rose(
                lvl_now[PSIC_EV_RXERR_HALF], lvl_q[PSIC_EV_RXERR_HALF]);
        end
    end

    // history of levels, compared against the live sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_q <= '0;
        else
            lvl_q <= lvl_now;
    end

    // the synchronisers still show their reset zeros for two edges,
    // so edges stay masked until the history holds real pin levels;
    // otherwise a link already up at reset would look like an event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_init_q <= 3'h0;
        else
            lvl_init_q <= {lvl_init_q[1:0], 1'b1};
    end

    // apb decode; byte address is index times four
    assign idx = paddr[9:2];
    assign sel_status = (idx == `PSIC_IDX_STATUS);
    assign sel_ictrl = (idx == `PSIC_IDX_ICTRL);
    assign sel_event = (idx == `PSIC_IDX_EVENT);
    // addresses beyond the map and sub-word offsets are refused
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                     && (sel_status || sel_ictrl || sel_event);
    assign acc_fire = psel & penable & (apb_q == PSIC_APB_IDLE);
    assign rd_event = acc_fire & ~pwrite & addr_ok & sel_event;

    // sticky event flags: a new event beats the clear of the read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_stat_q <= '0;
        else if (rd_event)
            ev_stat_q <= ev_hit;
        else
            ev_stat_q <= ev_stat_q | ev_hit;
    end

    // control and per-event enables; byte lane 0 carries control,
    // lane 0 alone carries event enables (status half is read only)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ictrl_q <= `PSIC_RST_ICTRL;
            ev_en_q <= `PSIC_RST_EV_EN;
        end
        else if (acc_fire && pwrite && addr_ok)
        begin
            if (sel_ictrl && pstrb[0])
                ictrl_q <= pwdata[2:0];
            if (sel_event && pstrb[0])
                ev_en_q <= pwdata[NEV-1:0];
        end
    end

    // read mux; unused bits read zero
    always_comb
    begin
        rdata_d = 16'h0000;
        if (sel_status)
        begin
            rdata_d[`PSIC_STS_LINK] = s_link;
            rdata_d[`PSIC_STS_SPEED10] = s_spd10;
            rdata_d[`PSIC_STS_DUPLEX] = s_dup;
            rdata_d[`PSIC_STS_LOOPBACK] = s_loop;
            rdata_d[`PSIC_STS_ANEG_DONE] = s_andone;
            rdata_d[`PSIC_STS_JABBER] = s_jab;
        end
        else if (sel_ictrl)
            rdata_d = {13'h0000, ictrl_q} & `PSIC_IC_MASK;
        else if (sel_event)
        begin
            rdata_d[`PSIC_EV_STAT_LSB +: NEV] = ev_stat_q;
            rdata_d[NEV-1:0] = ev_en_q;
        end
    end

    // one wait state: answer lands the cycle after the access phase
    // starts, so read data is registered like every other output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_q <= PSIC_APB_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            unique case (apb_q)
                PSIC_APB_IDLE:
                begin
                    if (acc_fire)
                    begin
                        apb_q <= PSIC_APB_DONE;
                        pready <= 1'b1;
                        pslverr <= ~addr_ok;
                        prdata <= (addr_ok && !pwrite)
                                  ? {16'h0000, rdata_d} : 32'h0000_0000;
                    end
                end
                PSIC_APB_DONE:
                begin
                    apb_q <= PSIC_APB_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // irq request from test force or gated enabled events
    assign irq_d = ictrl_q[`PSIC_IC_TEST]
                   | (ictrl_q[`PSIC_IC_EV_EN]
                      & |(ev_stat_q & ev_en_q));

    // shared pin: driven active high only while selected as irq output;
    // otherwise released and sampled as a powerdown request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pending <= 1'b0;
            powerdown_or_irq_pin_o <= 1'b0;
            powerdown_or_irq_pin_oe <= 1'b0;
            powerdown_req <= 1'b0;
            s_pd_pin_q <= 1'b0;
        end
        else
        begin
            irq_pending <= irq_d;
            s_pd_pin_q <= s_pd_pin;
            powerdown_or_irq_pin_oe <= ictrl_q[`PSIC_IC_PIN_OE];
            powerdown_or_irq_pin_o <= irq_d
                                      & ictrl_q[`PSIC_IC_PIN_OE];
            powerdown_req <= ~ictrl_q[`PSIC_IC_PIN_OE] & ~|oe_hist_q
                             & s_pd_pin_q;
        end
    end

    // recent pin-enable history; after the pin is released the
    // synchroniser still holds our own driven level for a few edges,
    // which must not be read back as a powerdown request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oe_hist_q <= 4'h0;
        else
            oe_hist_q <= {oe_hist_q[2:0], ictrl_q[`PSIC_IC_PIN_OE]};
    end
endmodule // psic_top

// >>> bench/psic_checker_assertions.sv
// port-level assertions for the phy status/irq block
`timescale 1ns/1ns
module psic_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic powerdown_or_irq_pin_o,
    input wire logic powerdown_or_irq_pin_oe,
    input wire logic powerdown_req,
    input wire logic irq_pending
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    // access edge still waiting for the answer
    assign acc = psel && penable && !pready;
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("answer not one cycle after access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    a_write_rdata: assert property (acc && pwrite |=> prdata == 32'h0)
        else $error("read data not zero on write");
    a_ctrl_reserved: assert property (
        acc && !pwrite && paddr == 12'h044 |=> prdata[31:3] == 29'h0)
        else $error("control reserved bits not zero");
    a_test_forces: assert property (
        acc && !pwrite && paddr == 12'h044 |=> !prdata[2] || irq_pending)
        else $error("test bit set without irq");
    a_pin_follows: assert property (
        powerdown_or_irq_pin_o == (irq_pending && powerdown_or_irq_pin_oe))
        else $error("pin does not follow irq");
    a_pd_settle: assert property (
        $fell(powerdown_or_irq_pin_oe) |-> (!powerdown_req)[*4])
        else $error("powerdown seen while pin released");
    a_oe_no_pdreq: assert property (
        powerdown_or_irq_pin_oe[*5] |-> !powerdown_req)
        else $error("powerdown while pin is output");
    cp_err: cover property (pslverr);
    cp_irq: cover property (irq_pending && powerdown_or_irq_pin_oe);
    cp_pd: cover property (powerdown_req);
endmodule // psic_checker
bind psic_top psic_checker psic_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .powerdown_or_irq_pin_o(powerdown_or_irq_pin_o),
    .powerdown_or_irq_pin_oe(powerdown_or_irq_pin_oe),
    .powerdown_req(powerdown_req), .irq_pending(irq_pending));

// >>> bench/psic_host.sv
// apb master standing in for the station management host
`timescale 1ns/1ns
module psic_host
(
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    // bus idle from time zero
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // one transfer; idle edge after so back-to-back calls never collide
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // psic_host

// >>> bench/test_phy_status_irq_control.sv
// self-checking bench for the phy status/irq block
`timescale 1ns/1ns
`include "psic_defines.svh"
module test_phy_status_irq_control;
    localparam logic [11:0] A_ST = {2'h0, `PSIC_IDX_STATUS, 2'h0};
    localparam logic [11:0] A_IC = {2'h0, `PSIC_IDX_ICTRL, 2'h0};
    localparam logic [11:0] A_EV = {2'h0, `PSIC_IDX_EVENT, 2'h0};
    logic pclk, presetn, aneg_en, loop_on, jab, ext_pin, err;
    logic [6:0] src;
    logic [31:0] rd_v;
    int n_mismatch, total_checks;
    wire psel, penable, pwrite, pready, pslverr, pin_o, pin_oe, pd, irq;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0] pstrb;
    // shared pin: block drives only with oe high
    wire pin_lvl = pin_oe ? pin_o : ext_pin;
    psic_top psic_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_up(src[5]), .speed_10(src[4]), .full_duplex(src[3]),
        .loopback_on(loop_on), .aneg_enabled(aneg_en),
        .aneg_complete(src[2]), .jabber_seen(jab), .energy_detect(src[6]),
        .fcs_cnt_half(src[1]), .rxerr_cnt_half(src[0]),
        .powerdown_or_irq_pin_i(pin_lvl), .powerdown_or_irq_pin_o(pin_o),
        .powerdown_or_irq_pin_oe(pin_oe), .powerdown_req(pd),
        .irq_pending(irq));
    psic_host psic_host_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    // 100 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        psic_host_inst.xfer(1'b1, a, d, rd_v, err);
    endtask
    task rd(input logic [11:0] a);
        psic_host_inst.xfer(1'b0, a, 32'h0, rd_v, err);
    endtask
    // covers the 2-flop input sync plus edge detect
    task wt;
        repeat (6) @(posedge pclk);
    endtask
    task s_status;
        src <= 7'h30;
        loop_on <= 1'b1;
        jab <= 1'b1;
        wt();
        rd(A_ST); chk("status", 32'h2B, rd_v);
        rd(A_ST); chk("status", 32'h2B, rd_v);
        src <= 7'h2C;
        loop_on <= 1'b0;
        jab <= 1'b0;
        wt();
        rd(A_ST); chk("status", 32'h15, rd_v);
        src <= 7'h28;
        wt();
        rd(A_EV); chk("event", 32'h3C00, rd_v);
    endtask
    // every source toggled alone, nothing enabled
    task s_sources;
        for (int i = 0; i < 7; i++)
        begin
            src[i] <= ~src[i];
            wt();
            rd(A_EV); chk("event", 32'h1 << (8 + i), rd_v);
        end
        rd(A_EV); chk("event", 32'h0, rd_v);
        // link up, autoneg on but not done: duplex change is no event
        aneg_en <= 1'b1;
        src <= 7'h7B;
        wt();
        rd(A_EV); chk("event", 32'h2000, rd_v);
    endtask
    task s_irq;
        wr(A_EV, 32'h40);
        src[6] <= ~src[6];
        wt();
        chk("irq", 32'h0, {31'h0, irq});
        rd(A_EV); chk("event", 32'h4040, rd_v);
        wr(A_IC, 32'h3);
        src[6] <= ~src[6];
        wt();
        chk("pin", 32'h3, {30'h0, pin_oe, pin_o});
        rd(A_EV); chk("event", 32'h4040, rd_v);
        wt();
        chk("pin", 32'h2, {30'h0, pin_oe, pin_o});
        src[5] <= ~src[5];
        wt();
        chk("pin", 32'h2, {30'h0, pin_oe, pin_o});
        rd(A_EV); chk("event", 32'h2040, rd_v);
    endtask
    // mid-run reset with sources high: no false event after it
    task s_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pin", 32'h0, {30'h0, pin_oe, pin_o});
        wt();
        rd(A_EV); chk("event", 32'h0, rd_v);
        rd(A_IC); chk("ctrl", 32'h0, rd_v);
    endtask
    task s_test;
        wr(A_IC, 32'hFFFF_FFFD);
        wt();
        rd(A_IC); chk("ctrl", 32'h5, rd_v);
        chk("pin", 32'h3, {30'h0, pin_oe, pin_o});
        wr(A_IC, 32'h0);
        ext_pin <= 1'b1;
        wt();
        chk("pin", 32'h0, {30'h0, pin_oe, pin_o});
        chk("pdreq", 32'h1, {31'h0, pd});
        wr(A_IC, 32'h1);
        wt();
        chk("pdreq", 32'h0, {31'h0, pd});
        wr(A_IC + 12'h1, 32'h4);
        chk("err", 32'h1, {31'h0, err});
        rd(12'h04C);
        chk("err", 32'h1, {31'h0, err});
        rd(A_IC); chk("ctrl", 32'h1, rd_v);
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        presetn = 1'b0;
        {src, aneg_en, loop_on, jab, ext_pin} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_IC); chk("ctrl", 32'h0, rd_v);
        rd(A_EV); chk("event", 32'h0, rd_v);
        s_status();
        s_sources();
        s_irq();
        s_test();
        s_reset();
        results();
    end
    // hang guard, far beyond the few hundred cycles used
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        results();
    end
endmodule // test_phy_status_irq_control
